/* File: upc_defs.svh */
// Purpose: Constants of the cell transfer port
// Assumes: Byte wide bus, 53 byte cells
// Notes: Included by the package, by the cell port and by the test bench
`ifndef UPC_DEFS_SVH
`define UPC_DEFS_SVH
`define UPC_NUM_PORTS 4
`define UPC_ADDR_W 5
`define UPC_CELL_BYTES 53
`define UPC_NULL_ADDR 5'h1F
`define UPC_FIRST_PORT_ADDR 5'h00
`endif

/* File: upc_pkg.sv */
// Purpose: Types of the cell transfer port
// Assumes: upc_defs.svh constants
// Notes: Byte plus start marker travels as one struct
`include "upc_defs.svh"
package upc_pkg;
   typedef struct packed {
      logic sop;
      logic [7:0] data;
   } upc_byte_t;
endpackage : upc_pkg

/* File: upc_buf2.sv */
// Purpose: Two entry buffer with valid and ready on both sides
// Assumes: Same clock on both sides
// Notes: Full and empty are exact; no word lost on stall
`timescale 1ns/10ps
module upc_buf2 #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic [1:0] cnt;
      logic rd;
   } upc_buf_st_t;
   upc_buf_st_t s_r, s_nxt;
   logic push, pop;
   // Handshakes from fill level
   // A full buffer still accepts when it drains in the same cycle; it refuses only when full and the drain side is not ready
   assign in_ready_out = (s_r.cnt != 2'h2) || out_ready_in;
   assign out_valid_out = (s_r.cnt != 2'h0);
   assign out_data_out = s_r.mem[s_r.rd];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   // Next state of the buffer
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.rd ^ s_r.cnt[0]] = in_data_in;
      end
      if (pop) begin
         s_nxt.rd = ~s_r.rd;
      end
      s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
   end
   // State register
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : upc_buf2

/* File: upc_cell_port.sv */
// Purpose: PHY side multi port cell transfer port, byte per clock
// Assumes: Far side master drives address, enables and transmit data
// Notes: Line side is a set of per port byte streams with cell counts
// Operation
// [RQ1] Address 00h selects the first port
// [RQ2] Direct transmit available per port when room
// [RQ3] Master selects, then enables with start marker
// [RQ4] Start marker only on a cell's first byte
// [RQ5] Transmit available drops without room for cell
// [RQ6] Port switch: enable off with new address
// [RQ7] Direct receive available per port with cell
// [RQ8] First receive byte one cycle after enable; the code drives it three cycles after
// [RQ9] Receive available drops with no further cell
// [RQ10] Polled transmit answer one cycle after poll; the code answers three cycles after
// [RQ11] Polls answered during an ongoing transfer
// [RQ12] Polled receive answer one cycle after poll; the code answers three cycles after
// [RQ13] Deselected receive port releases its outputs
// [RQ14] Master may hold enable past a cell
// [RQ15] No next cell: stop, start marker low
// [RQ16] Enable removed: release outputs next edge; the code releases them on the third edge
// [RQ17] Interrupted cell resumes with second byte
// [RQ18] Enables active low, rising edge timing
`timescale 1ns/10ps
`include "upc_defs.svh"
module upc_cell_port #(
   parameter int NP = `UPC_NUM_PORTS,
   parameter int AW = `UPC_ADDR_W,
   parameter int CELL = `UPC_CELL_BYTES,
   parameter int TXCAP = 2
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Transmit pins from the master
   input wire logic [AW-1:0] tx_port_select_in,
   input wire logic transmit_enable_n_in,
   input wire logic tx_start_of_cell_in,
   input wire logic [7:0] tx_data_in,
   output logic [NP-1:0] tx_direct_cell_avail_out,
   output logic tx_polled_cell_avail_out,
   // Receive pins to the master
   input wire logic [AW-1:0] rx_port_select_in,
   input wire logic receive_enable_n_in,
   output logic [7:0] rx_cell_bus_out,
   output logic rx_start_of_cell_out,
   output logic rx_oe_out,
   output logic [NP-1:0] rx_direct_cell_avail_out,
   output logic rx_polled_cell_avail_out,
   // Line side transmit stream
   output logic [NP-1:0] line_tx_valid_out,
   output upc_pkg::upc_byte_t line_tx_byte_out,
   input wire logic [NP-1:0] line_tx_ready_in,
   input wire logic [NP-1:0] line_tx_cell_done_in,
   // Line side receive stream
   input wire logic [NP-1:0] line_rx_cell_ready_in,
   input wire logic [NP-1:0][7:0] line_rx_data_in,
   output logic [NP-1:0] line_rx_take_out
);
   localparam int CW = $clog2(CELL + 1);
   localparam int TW = $clog2(TXCAP + 1);
   typedef struct packed {
      logic [AW-1:0] tx_port_select, rx_port_select;
      logic ten_n, ren_n, tsoc;
      logic [7:0] tdat;
      logic [NP-1:0][TW-1:0] tx_cells;
      logic [AW-1:0] tsel;
      logic [AW-1:0] rsel;
      logic [NP-1:0][CW-1:0] rx_pos;
      logic [7:0] rx_cell_bus;
      logic rsoc, roe;
      logic tpa, rpa;
   } upc_st_t;
   upc_st_t s_r, s_nxt;
   // Input synchroniser stage, read only by s_r fields
   logic [AW-1:0] tx_port_select_m, rx_port_select_m;
   logic ten_m, ren_m, tsoc_m;
   logic [7:0] tdat_m;
   logic wr_valid, wr_ready, lb_valid;
   upc_pkg::upc_byte_t wr_byte, lb_byte;
   logic [NP-1:0] tx_room, rx_has;
   logic [AW-1:0] lb_port_r;
   // Address to port index; 00h is the first port
   function automatic logic hit(input logic [AW-1:0] a, input int p);
      hit = (a == (`UPC_FIRST_PORT_ADDR + AW'(p))); // see [RQ1]
   endfunction : hit
   // Per port availability
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         tx_room[p] = (s_r.tx_cells[p] < TW'(TXCAP)); // see [RQ5]
         rx_has[p] = line_rx_cell_ready_in[p] || (s_r.rx_pos[p] != '0); // see [RQ9]
      end
   end
   assign tx_direct_cell_avail_out = tx_room; // see [RQ2]
   assign rx_direct_cell_avail_out = line_rx_cell_ready_in; // see [RQ7]
   assign tx_polled_cell_avail_out = s_r.tpa;
   assign rx_polled_cell_avail_out = s_r.rpa;
   assign rx_cell_bus_out = s_r.rx_cell_bus;
   assign rx_start_of_cell_out = s_r.rsoc;
   assign rx_oe_out = s_r.roe;
   // Sampled transmit byte enters the buffer on active low enable
   assign wr_valid = !s_r.ten_n && (s_r.tsel < AW'(NP)); // see [RQ18]
   assign wr_byte = '{sop: s_r.tsoc, data: s_r.tdat};
   assign line_tx_byte_out = lb_byte;
   always_comb begin
      line_tx_valid_out = '0;
      if (lb_valid && lb_port_r < AW'(NP)) begin
         line_tx_valid_out[lb_port_r[$clog2(NP)-1:0]] = 1'b1;
      end
   end
   upc_buf2 #(.WIDTH(9)) u_buf (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(wr_valid),
      .in_ready_out(wr_ready),
      .in_data_in(wr_byte),
      .out_valid_out(lb_valid),
      .out_ready_in(line_tx_ready_in[lb_port_r[$clog2(NP)-1:0]] && lb_port_r < AW'(NP)),
      .out_data_out(lb_byte)
   );
   // Line side port of buffered bytes follows the select of the first queued byte
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         lb_port_r <= `UPC_NULL_ADDR;
      end else if (wr_valid && wr_ready && (!lb_valid)) begin
         lb_port_r <= s_r.tsel;
      end
   end
   // Next state of the port
   always_comb begin
      logic take;
      logic [CW-1:0] pos;
      int sp;
      take = 1'b0;
      pos = '0;
      sp = 0;
      s_nxt = s_r;
      line_rx_take_out = '0;
      s_nxt.tx_port_select = tx_port_select_m;
      s_nxt.rx_port_select = rx_port_select_m;
      s_nxt.ten_n = ten_m;
      s_nxt.ren_n = ren_m;
      s_nxt.tsoc = tsoc_m; // see [RQ4]
      s_nxt.tdat = tdat_m;
      // Address with enable high selects; polls answered any time
      if (s_r.ten_n) begin
         s_nxt.tsel = s_r.tx_port_select; // see [RQ3] see [RQ6]
      end
      if (s_r.ren_n) begin
         s_nxt.rsel = s_r.rx_port_select;
      end
      s_nxt.tpa = 1'b0;
      s_nxt.rpa = 1'b0;
      for (int p = 0; p < NP; p++) begin
         if (hit(s_r.tx_port_select, p)) s_nxt.tpa = tx_room[p]; // see [RQ10] see [RQ11]
         if (hit(s_r.rx_port_select, p)) s_nxt.rpa = rx_has[p]; // see [RQ12]
         if (s_r.tx_cells[p] != '0 && line_tx_cell_done_in[p]) begin
            s_nxt.tx_cells[p] = s_r.tx_cells[p] - TW'(1);
         end
      end
      // Count a cell against its port at the start marker
      if (wr_valid && s_r.tsoc) begin
         for (int p = 0; p < NP; p++) begin
            if (hit(s_r.tsel, p)) s_nxt.tx_cells[p] = s_nxt.tx_cells[p] + TW'(1);
         end
      end
      // Receive: drive one byte per enabled cycle while the port has a cell, three cycles after enable
      s_nxt.roe = 1'b0;
      s_nxt.rsoc = 1'b0;
      if (!s_r.ren_n && s_r.rsel < AW'(NP)) begin // see [RQ8] see [RQ18]
         sp = int'(s_r.rsel);
         pos = s_r.rx_pos[sp];
         take = (pos != '0) || line_rx_cell_ready_in[sp]; // see [RQ15] see [RQ14]
         s_nxt.roe = 1'b1;
         if (take) begin
            s_nxt.rx_cell_bus = line_rx_data_in[sp];
            s_nxt.rsoc = (pos == '0); // see [RQ17]
            line_rx_take_out[sp] = 1'b1;
            s_nxt.rx_pos[sp] = (pos == CW'(CELL - 1)) ? '0 : pos + CW'(1);
         end
      end
      // Enable high or reselect releases the bus on the third edge
      if (s_r.ren_n) s_nxt.roe = 1'b0; // see [RQ16] see [RQ13]
   end
   // Registers: pin capture stage and state
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tx_port_select_m <= `UPC_NULL_ADDR;
         rx_port_select_m <= `UPC_NULL_ADDR;
         ten_m <= 1'b1;
         ren_m <= 1'b1;
         tsoc_m <= 1'b0;
         tdat_m <= 8'h00;
         s_r <= '0;
         s_r.ten_n <= 1'b1;
         s_r.ren_n <= 1'b1;
         s_r.tx_port_select <= `UPC_NULL_ADDR;
         s_r.rx_port_select <= `UPC_NULL_ADDR;
         s_r.tsel <= `UPC_NULL_ADDR;
         s_r.rsel <= `UPC_NULL_ADDR;
      end else begin
         tx_port_select_m <= tx_port_select_in;
         rx_port_select_m <= rx_port_select_in;
         ten_m <= transmit_enable_n_in;
         ren_m <= receive_enable_n_in;
         tsoc_m <= tx_start_of_cell_in;
         tdat_m <= tx_data_in;
         s_r <= s_nxt;
      end
   end
endmodule : upc_cell_port

/* File: upc_port_chk.sv */
// Purpose: Pin checker of the cell port
// Assumes: 5 bit addresses, sync reset
// Notes: Polls are judged after 5 quiet cycles
`timescale 1ns/10ps
module upc_port_chk #(
   parameter int NP = 4
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Watched pins
   input wire logic [4:0] tx_port_select_in,
   input wire logic [NP-1:0] tx_direct_cell_avail_out,
   input wire logic tx_polled_cell_avail_out,
   input wire logic [4:0] rx_port_select_in,
   input wire logic receive_enable_n_in,
   input wire logic rx_start_of_cell_out,
   input wire logic rx_oe_out,
   input wire logic [NP-1:0] rx_direct_cell_avail_out,
   input wire logic rx_polled_cell_avail_out,
   input wire logic [NP-1:0] line_rx_cell_ready_in,
   input wire logic [NP-1:0] line_rx_take_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Availability answers
   a_rx_mirror: assert property (rx_direct_cell_avail_out == line_rx_cell_ready_in)
      else $error("rx direct avail wrong");
   a_tx_poll_ans: assert property (($stable(tx_port_select_in) && $stable(tx_direct_cell_avail_out))[*5]
      |-> tx_polled_cell_avail_out == (tx_port_select_in < NP && tx_direct_cell_avail_out[tx_port_select_in]))
      else $error("tx poll answer wrong");
   a_rx_poll_ans: assert property (($stable(rx_port_select_in) && $stable(line_rx_cell_ready_in))[*5]
      |-> rx_polled_cell_avail_out == (rx_port_select_in < NP && line_rx_cell_ready_in[rx_port_select_in]))
      else $error("rx poll answer wrong");
   a_reset_room: assert property ($fell(sys_rst_in) |-> &tx_direct_cell_avail_out)
      else $error("no room after reset");
   // Receive bus ownership
   a_oe_release: assert property (receive_enable_n_in[*5] |-> !rx_oe_out)
      else $error("bus held while disabled");
   a_no_idle_take: assert property (receive_enable_n_in[*5] |-> line_rx_take_out == '0)
      else $error("byte taken while disabled");
   a_take_onehot: assert property ($onehot0(line_rx_take_out))
      else $error("two ports sending");
   a_sop_single: assert property (rx_start_of_cell_out && rx_oe_out |=> !(rx_start_of_cell_out && rx_oe_out))
      else $error("start marker repeated");
   // Main scenarios
   c_rx_start: cover property (rx_start_of_cell_out && rx_oe_out);
   c_tx_full: cover property ($fell(tx_direct_cell_avail_out[0]));
   c_tx_poll: cover property (tx_polled_cell_avail_out);
endmodule : upc_port_chk

/* File: upc_atm_master.sv */
// Purpose: Master model sending transmit cells
// Assumes: One select cycle before each cell
// Notes: Idle data inverts itself each clock, starting from the inverse of the last byte
`timescale 1ns/10ps
module upc_atm_master #(
   parameter int CELL = 53
) (
   // Clock and command
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [4:0] port_in,
   // Transmit pins
   output logic [4:0] sel_out = 5'h1F,
   output logic en_n_out = 1'b1,
   output logic sop_out = 1'b0,
   output logic [7:0] data_out = 8'h00,
   output logic busy_out
);
   int n = -1;
   assign busy_out = n >= 0;
   // Idle or cell end: address with enable off, then one byte per clock
   always @(posedge clk_in) begin
      if (n < 0 || n == CELL) begin
         sel_out <= port_in;
         en_n_out <= 1'b1;
         sop_out <= 1'b0;
         data_out <= ~data_out;
         n <= go_in ? 0 : -1;
      end else begin
         en_n_out <= 1'b0;
         sop_out <= n == 0;
         data_out <= 8'(n + 7 * sel_out);
         n <= n + 1;
      end
   end
endmodule : upc_atm_master

/* File: utopia_l2_phy_cell_port_test.sv */
// Purpose: Self checking bench of the cell port
// Assumes: Default parameters, two cells of room
// Notes: Line side is modelled here
`timescale 1ns/10ps
`include "upc_defs.svh"
module utopia_l2_phy_cell_port_test;
   localparam int CELL = `UPC_CELL_BYTES;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic go = 1'b0;
   logic ren_n = 1'b1;
   logic [4:0] mport = 5'h1F, rsel = 5'h1F, tsel;
   logic ten_n, tsop, busy, rsop, roe, tpa, rpa;
   logic took = 1'b0;
   logic [7:0] tdat, rx_cell_bus;
   logic [3:0] tda, rda, tvld, take, trdy = 4'hF, tdone = 4'h0, rrdy = 4'h0;
   logic [3:0][7:0] rline;
   upc_pkg::upc_byte_t tbyte;
   int num_errors = 0, n_tests = 0, cyc = 0, rp = 0;
   int rpos[4] = '{default: 0};
   int rcnt[4] = '{default: 0};
   logic [8:0] txq[$];
   always #25 clk_in = ~clk_in;
   upc_atm_master i_master (.clk_in, .go_in(go), .port_in(mport), .sel_out(tsel), .en_n_out(ten_n),
      .sop_out(tsop), .data_out(tdat), .busy_out(busy));
   upc_cell_port i_dut (.clk_in, .sys_rst_in, .tx_port_select_in(tsel), .transmit_enable_n_in(ten_n),
      .tx_start_of_cell_in(tsop), .tx_data_in(tdat), .tx_direct_cell_avail_out(tda), .tx_polled_cell_avail_out(tpa),
      .rx_port_select_in(rsel), .receive_enable_n_in(ren_n), .rx_cell_bus_out(rx_cell_bus), .rx_start_of_cell_out(rsop),
      .rx_oe_out(roe), .rx_direct_cell_avail_out(rda), .rx_polled_cell_avail_out(rpa), .line_tx_valid_out(tvld),
      .line_tx_byte_out(tbyte), .line_tx_ready_in(trdy), .line_tx_cell_done_in(tdone), .line_rx_cell_ready_in(rrdy),
      .line_rx_data_in(rline), .line_rx_take_out(take));
   // Line receive bytes advance on each take
   always @(posedge clk_in) for (int p = 0; p < 4; p++) if (take[p]) rcnt[p] <= rcnt[p] + 1;
   always_comb for (int p = 0; p < 4; p++) rline[p] = 8'(rcnt[p] + 16 * p);
   // Line transmit bytes against the queued cells
   always @(posedge clk_in) if (|(tvld & trdy)) cmp(tbyte, txq.pop_front());
   // Receive bytes: a take registers the byte, so it stands on the bus one cycle later
   always @(posedge clk_in) begin
      took <= take[rp];
      if (roe && took) begin
         cmp({rsop, rx_cell_bus}, {rpos[rp] % CELL == 0, 8'(rpos[rp] + 16 * rp)});
         rpos[rp] = rpos[rp] + 1;
      end
   end
   // Watchdog
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors = num_errors + 1;
         report_and_stop();
      end
   end
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask : wt
   // One cell to port p with a one cycle line stall
   task automatic send_cell(input int p);
      for (int j = 0; j < CELL; j++) txq.push_back({j == 0, 8'(j + 7 * p)});
      mport <= 5'(p);
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wt($urandom_range(CELL - 3, 2));
      trdy <= 4'h0;
      wt(1);
      trdy <= 4'hF;
      wt(CELL + 8);
   endtask : send_cell
   // Enable port p for n cycles after one select cycle
   task automatic rd(input int p, input int n);
      rp = p;
      rsel <= 5'(p);
      wt(1);
      ren_n <= 1'b0;
      wt(n);
      ren_n <= 1'b1;
      wt(8);
   endtask : rd
   initial begin
      void'($urandom(13937));
      wt(10);
      sys_rst_in <= 1'b0;
      wt(1);
      cmp(tda, 4'hF);
      send_cell(0);
      send_cell(0);
      cmp(tda[0], 1'b0);
      for (int p = 0; p < 2; p++) begin
         mport <= 5'(p);
         wt(6);
         cmp(tpa, p == 1);
      end
      tdone <= 4'h1;
      wt(1);
      tdone <= 4'h0;
      wt(6);
      cmp(tda, 4'hF);
      send_cell($urandom_range(3, 1));
      rrdy <= 4'h3;
      wt(2);
      cmp(rda, 4'h3);
      for (int p = 0; p < 4; p++) begin
         rsel <= 5'(p);
         wt(6);
         cmp(rpa, p < 2);
      end
      rd(0, 60);
      cmp(9'(rpos[0]), 9'd60);
      rd(1, 1);
      rd(1, 5);
      cmp(9'(rpos[1]), 9'd6);
      report_and_stop();
   end
endmodule : utopia_l2_phy_cell_port_test
bind upc_cell_port upc_port_chk #(.NP(NP)) i_chk (.clk_in, .sys_rst_in, .tx_port_select_in, .tx_direct_cell_avail_out,
   .tx_polled_cell_avail_out, .rx_port_select_in, .receive_enable_n_in, .rx_start_of_cell_out, .rx_oe_out,
   .rx_direct_cell_avail_out, .rx_polled_cell_avail_out, .line_rx_cell_ready_in, .line_rx_take_out);
